/* File: core/ocss_buf2.sv */
// Purpose: two-entry buffer with valid and ready on both sides
// Assumes: single clock, asynchronous active-high reset
// Notes:   full and empty are exact; accepts and drains in the same cycle when holding one entry
`timescale 1ns/1ps
module ocss_buf2
    import ocss_pkg::*;
#(
    parameter int W = 16
)(
    input  wire logic         clk_sys,
    input  wire logic         rst,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    if (W < 1)
    begin : g_bad_width
        $error("ocss_buf2: width must be positive");
    end

    logic [W-1:0] ent0_r;
    logic [W-1:0] ent1_r;
    logic [1:0]   cnt_r;
    wire          push = in_valid && in_ready;
    wire          pop  = out_valid && out_ready;

    assign in_ready  = (cnt_r != 2'h2);
    assign out_valid = (cnt_r != 2'h0);
    assign out_data  = ent0_r;

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            cnt_r  <= 2'h0;
            ent0_r <= '0;
            ent1_r <= '0;
        end
        else
        begin
            cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
            if (pop)
            begin
                ent0_r <= (cnt_r == 2'h2) ? ent1_r : in_data;
                if (push && cnt_r == 2'h2)
                    ent1_r <= in_data;
            end
            else if (push)
            begin
                if (cnt_r == 2'h0)
                    ent0_r <= in_data;
                else
                    ent1_r <= in_data;
            end
        end
    end
endmodule : ocss_buf2

/* File: core/ocss_pkg.sv */
// Purpose: constants for the output channel source select block
// Assumes: frame timing from an external 4 MHz bit clock and frame pulse
// Notes:   rules of the block listed below
// Function
// - The top three bits of a connection word give the source input stream, bit 7 most significant.
// - The low five bits of a connection word give the source channel, bit 4 most significant.
// - With the channel message flag or the global message setting set, the whole word is sent unchanged.
// - Otherwise the stored input byte at the named stream and channel is sent.
// - While global message is one, every channel acts as if its message and driver-enable flags were set.
// - With the output gate pin low, every serial output floats.
// - With the gate high and global message zero, a channel drives only when its driver-enable flag is one.
package ocss_pkg;
    localparam int STREAMS        = 8;
    localparam int CHANNELS       = 32;
    localparam int BITS           = 8;
    localparam int STREAM_W       = 3;
    localparam int CHAN_W         = 5;
    localparam int LOC_W          = STREAM_W + CHAN_W;
    localparam int CW_STREAM_MSB  = 7;
    localparam int CW_STREAM_LSB  = 5;
    localparam int CW_CHAN_MSB    = 4;
    localparam int CW_CHAN_LSB    = 0;
    localparam int C4_PER_FRAME   = 512;
    localparam int CNT_W          = 9;
    localparam int BIT_CLK_NS     = 244;
    localparam int SYS_CLK_NS     = 25;
    // system clocks per bit-clock cycle, rounded down
    localparam int SYS_PER_C4     = BIT_CLK_NS / SYS_CLK_NS;
    localparam logic [7:0] WORD_RST = 8'h00;
    localparam logic [CNT_W-1:0] CNT_RST = 9'h000;
endpackage : ocss_pkg

/* File: core/ocss_top.sv */
// Purpose: per-output-channel source select and serial output of eight streams
// Assumes: bit clock, frame pulse, streams and gate pin are asynchronous pins
// Notes:   connection words and flags written through a plain write port
`timescale 1ns/1ps
module ocss_top
    import ocss_pkg::*;
(
    input  wire logic               clk_sys,
    input  wire logic               rst,
    input  wire logic               bit_clk_n_pin,
    input  wire logic               frame_n_pin,
    input  wire logic [STREAMS-1:0] serial_stream_input,
    input  wire logic               serial_out_gate_pin,
    input  wire logic               global_msg,
    input  wire logic               cfg_wr,
    input  wire logic [LOC_W-1:0]   cfg_loc,
    input  wire logic [7:0]         cfg_word,
    input  wire logic               cfg_msg_flag,
    input  wire logic               cfg_oe_flag,
    input  wire logic [LOC_W-1:0]   rd_loc,
    output logic [7:0]              rd_word,
    output logic [STREAMS-1:0]      serial_stream_output,
    output logic [STREAMS-1:0]      serial_stream_output_oe
);
    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    logic               c4_s1_r, c4_s2_r, c4_s3_r;
    logic               fp_s1_r, fp_s2_r;
    logic               gate_s1_r, gate_s2_r;
    logic [STREAMS-1:0] sti_s1_r, sti_s2_r;

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            {c4_s1_r, c4_s2_r, c4_s3_r} <= 3'h7;
            {fp_s1_r, fp_s2_r}          <= 2'h3;
            {gate_s1_r, gate_s2_r}      <= 2'h0;
            sti_s1_r                    <= '0;
            sti_s2_r                    <= '0;
        end
        else
        begin
            c4_s1_r   <= bit_clk_n_pin;
            c4_s2_r   <= c4_s1_r;
            c4_s3_r   <= c4_s2_r;
            fp_s1_r   <= frame_n_pin;
            fp_s2_r   <= fp_s1_r;
            gate_s1_r <= serial_out_gate_pin;
            gate_s2_r <= gate_s1_r;
            sti_s1_r  <= serial_stream_input;
            sti_s2_r  <= sti_s1_r;
        end
    end

    // ------------------------------------------------------------------
    // frame position counter, one step per bit-clock falling edge
    // ------------------------------------------------------------------
    logic [CNT_W-1:0] cnt_r;
    logic             framed_r;
    wire              c4_fall  = c4_s3_r && !c4_s2_r;
    wire [CNT_W-1:0]  cnt_nxt  = !fp_s2_r ? CNT_RST : cnt_r + 9'h001;
    wire              bit_mid  = c4_fall && cnt_nxt[0];
    wire              bit_edge = c4_fall && !cnt_nxt[0];
    wire              ch_start = bit_edge && (cnt_nxt[3:1] == 3'h0);
    wire              byte_end = bit_mid && (cnt_nxt[3:1] == 3'h7);
    wire [CHAN_W-1:0] chan_cur = cnt_r[CNT_W-1:4];
    wire [CHAN_W-1:0] chan_nxt = cnt_nxt[CNT_W-1:4];
    wire [CHAN_W-1:0] chan_fet = chan_cur + 5'h01;

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            cnt_r    <= CNT_RST;
            framed_r <= 1'b0;
        end
        else if (c4_fall)
        begin
            cnt_r <= cnt_nxt;
            if (!fp_s2_r)
                framed_r <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // input byte store and connection store
    // ------------------------------------------------------------------
    logic [7:0]           dmem_r  [STREAMS*CHANNELS];
    logic [7:0]           cword_r [STREAMS*CHANNELS];
    logic [STREAMS*CHANNELS-1:0] cmsg_r;
    logic [STREAMS*CHANNELS-1:0] coe_r;
    logic [BITS-2:0]      rx_sh_r [STREAMS];

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            cmsg_r <= '0;
            coe_r  <= '0;
        end
        else if (cfg_wr)
        begin
            cmsg_r[cfg_loc] <= cfg_msg_flag;
            coe_r[cfg_loc]  <= cfg_oe_flag;
        end
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            for (int i = 0; i < STREAMS * CHANNELS; i++)
                cword_r[i] <= WORD_RST;
        end
        else if (cfg_wr)
            cword_r[cfg_loc] <= cfg_word;
    end

    assign rd_word = cword_r[rd_loc];

    // ------------------------------------------------------------------
    // per stream: receive shifter, source decode and fetch
    // ------------------------------------------------------------------
    logic [7:0]          fet_byte [STREAMS];
    logic [STREAMS-1:0]  fet_oe;
    logic [STREAMS-1:0]  fet_msg;
    logic [STREAM_W-1:0] src_stream [STREAMS];
    logic [CHAN_W-1:0]   src_chan [STREAMS];

    genvar s;
    generate
        for (s = 0; s < STREAMS; s++)
        begin : g_str
            wire [LOC_W-1:0] own_loc = {STREAM_W'(s), chan_fet};
            wire [7:0]       w       = cword_r[own_loc];

            assign src_stream[s] = w[CW_STREAM_MSB:CW_STREAM_LSB];
            assign src_chan[s]   = w[CW_CHAN_MSB:CW_CHAN_LSB];
            assign fet_msg[s]    = global_msg || cmsg_r[own_loc];
            assign fet_byte[s]   = fet_msg[s] ? w
                                 : dmem_r[{src_stream[s], src_chan[s]}];
            assign fet_oe[s]     = global_msg || coe_r[own_loc];

            always_ff @(posedge clk_sys or posedge rst)
            begin
                if (rst)
                    rx_sh_r[s] <= '0;
                else if (bit_mid)
                    rx_sh_r[s] <= {rx_sh_r[s][BITS-3:0], sti_s2_r[s]};
            end
        end
    endgenerate

    // single writer for the whole byte store
    always_ff @(posedge clk_sys)
    begin
        if (byte_end && framed_r)
        begin
            for (int i = 0; i < STREAMS; i++)
                dmem_r[{STREAM_W'(i), chan_nxt}] <= {rx_sh_r[i], sti_s2_r[i]};
        end
    end

    // ------------------------------------------------------------------
    // fetch-ahead buffer: one entry holds the next channel for all streams
    // ------------------------------------------------------------------
    localparam int E_W = CHAN_W + STREAMS + BITS * STREAMS;
    logic [E_W-1:0]    push_data;
    logic [E_W-1:0]    pop_data;
    logic              push_ready;
    logic              pop_valid;
    logic [CHAN_W-1:0] last_tag_r;
    logic              have_tag_r;
    wire               push_want = framed_r && (!have_tag_r || last_tag_r != chan_fet);
    wire               push      = push_want && push_ready;

    always_comb
    begin
        push_data = '0;
        push_data[E_W-1 -: CHAN_W] = chan_fet;
        push_data[BITS*STREAMS +: STREAMS] = fet_oe;
        for (int i = 0; i < STREAMS; i++)
            push_data[i*BITS +: BITS] = fet_byte[i];
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            last_tag_r <= '0;
            have_tag_r <= 1'b0;
        end
        else if (push)
        begin
            last_tag_r <= chan_fet;
            have_tag_r <= 1'b1;
        end
    end

    ocss_buf2 #(.W(E_W)) u_buf (
        .clk_sys   (clk_sys),
        .rst       (rst),
        .in_valid  (push_want),
        .in_ready  (push_ready),
        .in_data   (push_data),
        .out_valid (pop_valid),
        .out_ready (ch_start),
        .out_data  (pop_data)
    );

    // ------------------------------------------------------------------
    // serializer: load at channel start, shift msb first
    // ------------------------------------------------------------------
    logic [BITS-1:0]    tx_sh_r [STREAMS];
    logic [STREAMS-1:0] tx_oe_r;
    wire                tag_ok = pop_valid && (pop_data[E_W-1 -: CHAN_W] == chan_nxt);

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            tx_oe_r <= '0;
            for (int i = 0; i < STREAMS; i++)
                tx_sh_r[i] <= '0;
        end
        else if (ch_start)
        begin
            tx_oe_r <= tag_ok ? pop_data[BITS*STREAMS +: STREAMS] : '0;
            for (int i = 0; i < STREAMS; i++)
                tx_sh_r[i] <= pop_data[i*BITS +: BITS];
        end
        else if (bit_edge)
        begin
            for (int i = 0; i < STREAMS; i++)
                tx_sh_r[i] <= {tx_sh_r[i][BITS-2:0], 1'b0};
        end
    end

    always_comb
    begin
        for (int i = 0; i < STREAMS; i++)
            serial_stream_output[i] = tx_sh_r[i][BITS-1];
    end
    assign serial_stream_output_oe = tx_oe_r & {STREAMS{gate_s2_r}};

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    chk_stream_field: assert property (@(posedge clk_sys) disable iff (rst)
        src_stream[0] == cword_r[{3'h0, chan_fet}][7:5])
        else $error("source stream field wrong");
    chk_chan_field: assert property (@(posedge clk_sys) disable iff (rst)
        src_chan[STREAMS-1] == cword_r[{3'h7, chan_fet}][4:0])
        else $error("source channel field wrong");
    chk_msg_verbatim: assert property (@(posedge clk_sys) disable iff (rst)
        (cmsg_r[{3'h2, chan_fet}] || global_msg) |-> fet_byte[2] == cword_r[{3'h2, chan_fet}])
        else $error("message word not sent verbatim");
    chk_switch_byte: assert property (@(posedge clk_sys) disable iff (rst)
        (!global_msg && !cmsg_r[{3'h1, chan_fet}])
        |-> fet_byte[1] == dmem_r[cword_r[{3'h1, chan_fet}]])
        else $error("switched byte from wrong location");
    chk_global_force: assert property (@(posedge clk_sys) disable iff (rst)
        global_msg |-> (&fet_oe && &fet_msg))
        else $error("global message did not force flags");
    chk_gate_float: assert property (@(posedge clk_sys) disable iff (rst)
        !gate_s2_r |-> serial_stream_output_oe == '0)
        else $error("output driven with gate low");
    chk_oe_flag: assert property (@(posedge clk_sys) disable iff (rst)
        (!global_msg && !coe_r[{3'h4, chan_fet}]) |-> !fet_oe[4])
        else $error("driver enabled with flag clear");
    chk_fetch_tag: assert property (@(posedge clk_sys) disable iff (rst)
        push |=> (have_tag_r && last_tag_r == $past(chan_fet)))
        else $error("fetch tag not tracked");
    chk_load_hold: assert property (@(posedge clk_sys) disable iff (rst)
        (ch_start && !tag_ok) |=> tx_oe_r == '0)
        else $error("stale entry drove a channel");
endmodule : ocss_top

/* File: verif/ocss_pcm_src.sv */
// Purpose: serial stream source with bit clock and frame pulse
// Assumes: bit clock runs free, one frame pulse every 512 bit clocks
// Notes:   stream s channel k carries {k,s} ^ 8'h3c, msb first
`timescale 1ns/1ps
module ocss_pcm_src
    import ocss_pkg::*;
(
    output logic               bit_clk_n_pin,
    output logic               frame_n_pin,
    output logic [STREAMS-1:0] serial_stream_input,
    output logic [CNT_W-1:0]   pos
);
    logic [7:0] src;
    int         s;
    initial
    begin
        bit_clk_n_pin       = 1'b1;
        frame_n_pin         = 1'b1;
        serial_stream_input = 8'h00;
        pos                 = 9'h1ff;
        forever
        begin
            #(BIT_CLK_NS / 2);
            bit_clk_n_pin = 1'b0;
            pos           = pos + 9'h001;
            // new bit on even positions, held two bit clocks
            if (pos[0] == 1'b0)
            begin
                for (s = 0; s < STREAMS; s++)
                begin
                    src                    = {pos[8:4], s[2:0]} ^ 8'h3c;
                    serial_stream_input[s] = src[~pos[3:1]];
                end
            end
            #(BIT_CLK_NS / 2);
            bit_clk_n_pin = 1'b1;
            // low across the falling edge that starts position 0
            frame_n_pin   = (pos == 9'h1ff) ? 1'b0 : 1'b1;
        end
    end
endmodule : ocss_pcm_src

/* File: verif/tb_ocss_top.sv */
// Purpose: self-checking bench for the output channel source select block
// Assumes: stream source model drives the pins; writes through cfg port
// Notes:   shadow copy of every location gives expected bytes and enables
`timescale 1ns/1ps
module tb_ocss_top
    import ocss_pkg::*;
;
    localparam int      DLY   = 2;
    localparam int      LIMIT = 12000;
    logic               clk_sys, rst, serial_out_gate_pin, global_msg;
    logic               cfg_wr, cfg_msg_flag, cfg_oe_flag, bit_clk_n_pin, frame_n_pin;
    logic [LOC_W-1:0]   cfg_loc, rd_loc;
    logic [7:0]         cfg_word, rd_word;
    logic [STREAMS-1:0] serial_stream_input, serial_stream_output, serial_stream_output_oe;
    logic [CNT_W-1:0]   pos;
    logic [7:0]         sh_word [STREAMS*CHANNELS];
    logic               sh_msg  [STREAMS*CHANNELS];
    logic               sh_oe   [STREAMS*CHANNELS];
    int                 fails, n_compared, i;

    ocss_top ocss_top_inst (.clk_sys(clk_sys), .rst(rst), .bit_clk_n_pin(bit_clk_n_pin),
        .frame_n_pin(frame_n_pin), .serial_stream_input(serial_stream_input),
        .serial_out_gate_pin(serial_out_gate_pin), .global_msg(global_msg), .cfg_wr(cfg_wr),
        .cfg_loc(cfg_loc), .cfg_word(cfg_word), .cfg_msg_flag(cfg_msg_flag), .cfg_oe_flag(cfg_oe_flag),
        .rd_loc(rd_loc), .rd_word(rd_word), .serial_stream_output(serial_stream_output),
        .serial_stream_output_oe(serial_stream_output_oe));
    ocss_pcm_src ocss_pcm_src_inst (.bit_clk_n_pin(bit_clk_n_pin), .frame_n_pin(frame_n_pin),
        .serial_stream_input(serial_stream_input), .pos(pos));

    initial
    begin
        clk_sys = 1'b0;
        forever #(SYS_CLK_NS / 2.0) clk_sys = ~clk_sys;
    end

    // ------------------------------------------------------------
    // compare, access and wait tasks
    // ------------------------------------------------------------
    task automatic test_done();
        $display("compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : test_done

    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp, input int loc);
        n_compared++;
        if (got !== exp)
        begin
            fails++;
            $display("Error at %0t: byte at loc %0d got %h expected %h", $time, loc, got, exp);
        end
    endtask : cmp8

    task automatic cmp1(input logic got, input logic exp, input int loc);
        n_compared++;
        if (got !== exp)
        begin
            fails++;
            $display("Error at %0t: enable at loc %0d got %b expected %b", $time, loc, got, exp);
        end
    endtask : cmp1

    task automatic put(input int s, input int j, input logic [7:0] w, input logic m, input logic e);
        @(posedge clk_sys);
        #DLY;
        cfg_wr       = 1'b1;
        cfg_loc      = {s[2:0], j[4:0]};
        cfg_word     = w;
        cfg_msg_flag = m;
        cfg_oe_flag  = e;
        sh_word[s*CHANNELS+j] = w;
        sh_msg[s*CHANNELS+j]  = m;
        sh_oe[s*CHANNELS+j]   = e;
        @(posedge clk_sys);
        #DLY;
        cfg_wr = 1'b0;
        rd_loc = {s[2:0], j[4:0]};
        @(posedge clk_sys);
        #DLY;
        cmp8(rd_word, sh_word[s*CHANNELS+j], s*CHANNELS+j);
    endtask : put

    task automatic wait_pos(input logic [CNT_W-1:0] target);
        int n;
        n = 0;
        @(posedge clk_sys);
        while (pos !== target && n < LIMIT)
        begin
            @(posedge clk_sys);
            n++;
        end
        if (n >= LIMIT)
        begin
            fails++;
            $display("Error at %0t: frame position %0d not reached", $time, target);
            test_done();
        end
    endtask : wait_pos

    task automatic wait_frames(input int n);
        repeat (n)
        begin
            wait_pos(9'h1f0);
            wait_pos(9'h000);
        end
    endtask : wait_frames

    // samples all streams of one channel at mid-bit, then checks bytes
    task automatic check_chan(input int j);
        logic [7:0] dat [STREAMS];
        logic [7:0] w;
        int         s, b, k;
        for (b = 0; b < BITS; b++)
        begin
            wait_pos({j[4:0], b[2:0], 1'b1});
            #DLY;
            for (s = 0; s < STREAMS; s++)
            begin
                k             = s * CHANNELS + j;
                dat[s][7 - b] = serial_stream_output[s];
                cmp1(serial_stream_output_oe[s], serial_out_gate_pin & (global_msg | sh_oe[k]), k);
            end
        end
        for (s = 0; s < STREAMS; s++)
        begin
            k = s * CHANNELS + j;
            w = sh_word[k];
            if (serial_out_gate_pin && (global_msg || sh_oe[k]) && (global_msg || sh_msg[k]))
                cmp8(dat[s], w, k);
            else if (serial_out_gate_pin && sh_oe[k])
                cmp8(dat[s], {w[4:0], w[7:5]} ^ 8'h3c, k);
        end
    endtask : check_chan

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        rst                 = 1'b1;
        serial_out_gate_pin = 1'b1;
        global_msg          = 1'b0;
        cfg_wr              = 1'b0;
        cfg_loc             = 8'h00;
        cfg_word            = 8'h00;
        cfg_msg_flag        = 1'b0;
        cfg_oe_flag         = 1'b0;
        rd_loc              = 8'h00;
        fails               = 0;
        n_compared          = 0;
        for (i = 0; i < STREAMS * CHANNELS; i++)
        begin
            sh_word[i] = 8'h00;
            sh_msg[i]  = 1'b0;
            sh_oe[i]   = 1'b0;
        end
        repeat (12) @(posedge clk_sys);
        #DLY;
        rst = 1'b0;
        wait_frames(2);
        check_chan(5);
        $display("test reset idle done");
        put(0, 2, 8'hff, 1'b0, 1'b1);
        put(7, 3, 8'h00, 1'b0, 1'b1);
        put(4, 3, 8'h93, 1'b0, 1'b1);
        put(1, 9, 8'h6a, 1'b0, 1'b0);
        put(2, 31, 8'h4a, 1'b0, 1'b1);
        wait_frames(2);
        check_chan(2);
        check_chan(3);
        check_chan(9);
        check_chan(31);
        check_chan(3);
        $display("test switched done");
        put(5, 3, 8'hc3, 1'b1, 1'b1);
        put(6, 9, 8'ha5, 1'b1, 1'b0);
        wait_frames(2);
        check_chan(3);
        check_chan(9);
        $display("test channel message done");
        global_msg = 1'b1;
        wait_frames(2);
        check_chan(3);
        check_chan(9);
        check_chan(20);
        $display("test global message done");
        serial_out_gate_pin = 1'b0;
        wait_frames(1);
        check_chan(3);
        $display("test gate low done");
        test_done();
    end
endmodule : tb_ocss_top
